// *** design/epss_child_table.sv ***
/*
  Parent-side child table: four slots, each aged in seconds since its child last polled.
  Assumes a one-cycle second tick and one poll or registration event per cycle at most.
*/
`timescale 1ns/10ps

module epss_child_table (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    sec_tick,
  input  wire logic [7:0]              timeout,
  input  wire epss_pkg::epss_child_ev_t reg_ev,
  input  wire epss_pkg::epss_child_ev_t poll_ev,
  output logic [3:0]                   present
);

  logic [7:0] age [4];

  // a registration, or a poll of a present slot, refreshes the slot; an expired slot is dropped
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        age[i]     <= 8'h00;
        present[i] <= 1'b0;
      end else if ((reg_ev.valid && reg_ev.id == 2'(i)) ||
                   (poll_ev.valid && poll_ev.id == 2'(i) && present[i])) begin
        age[i]     <= 8'h00;
        present[i] <= 1'b1;
      end else if (present[i] && sec_tick) begin
        age[i] <= age[i] + 8'h01;
        if (age[i] + 8'h01 >= timeout) begin
          present[i] <= 1'b0; // RULE2
        end
      end
    end
  end

endmodule

// *** design/epss_defines.svh ***
/*
  Register offsets, field positions, reset values and timing figures of the poll/sleep scheduler.
  Assumes a 20 MHz system clock and an 8-bit byte address on the register bus.
*/
`ifndef EPSS_DEFINES_SVH
`define EPSS_DEFINES_SVH

// register byte offsets
`define EPSS_OFF_CTRL       8'h00
`define EPSS_OFF_CHILD_TMO  8'h04
`define EPSS_OFF_IDLE_POLL  8'h08
`define EPSS_OFF_REJOIN     8'h0C
`define EPSS_OFF_DOZE       8'h10
`define EPSS_OFF_AWAKE_POLL 8'h14
`define EPSS_OFF_STANDBY    8'h18
`define EPSS_OFF_STATUS     8'h1C
`define EPSS_OFF_CMD        8'h20
`define EPSS_OFF_LINK_KEY   8'h30
`define EPSS_OFF_NWK_KEY    8'h40

// field positions
`define EPSS_CTRL_SEC_BIT   4
`define EPSS_CMD_REFRESH    0

// node type codes
`define EPSS_NT_COORD       3'h1
`define EPSS_NT_END         3'h3
`define EPSS_NT_SLEEPY      3'h4

// reset values
`define EPSS_RST_CHILD_TMO  8'h3C
`define EPSS_RST_IDLE_POLL  8'h05
`define EPSS_RST_REJOIN     8'h0A
`define EPSS_RST_DOZE       8'h08
`define EPSS_RST_AWAKE_POLL 16'h0064
`define EPSS_RST_STANDBY    8'h05
`define EPSS_RST_CHANNEL    5'h0C
`define EPSS_RST_KEY        128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF

// timing
`define EPSS_CLK_PERIOD_NS  50
`define EPSS_MS_NS          1000000
`define EPSS_MS_CYCLES      (`EPSS_MS_NS / `EPSS_CLK_PERIOD_NS)
`define EPSS_MS_PER_QTR     8'hFA
`define EPSS_QTR_PER_SEC    2'h3
`define EPSS_BLINK_QTRS     2'h2

// bus answers
`define EPSS_RESP_OKAY      2'h0
`define EPSS_RESP_SLVERR    2'h2

`endif

// *** design/epss_pkg.sv ***
/*
  Types of the poll/sleep scheduler: leaf state codes and the message carriers from the radio side.
  Assumes the defines header supplies all numeric constants.
*/
package epss_pkg;

  // one-hot leaf node states
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_DOZE   = 4'h4,
    ST_AWAKE  = 4'h8
  } epss_state_t;

  // key carried by a join request or a key update broadcast
  typedef struct packed {
    logic         valid;
    logic [127:0] key;
  } epss_key_msg_t;

  // child poll or registration event at the parent
  typedef struct packed {
    logic       valid;
    logic [1:0] id;
  } epss_child_ev_t;

  // channel change message from the network manager
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
  } epss_chan_msg_t;

endpackage

// *** design/epss_sched.sv ***
/*
  Poll and sleep scheduler of a wireless leaf node, with parent child-table aging,
  key storage, channel tracking and an AXI4-Lite register slave.
  Assumes the radio stack reports join, link, data and network messages as single-cycle
  pulses or levels synchronous to aclk.
*/
`timescale 1ns/10ps
`include "epss_defines.svh"

// Overview of operation
// RULE1: parent keeps a child poll timeout in seconds, 60 after reset.
// RULE2: a child silent past the timeout is dropped and no longer relayed.
// RULE3: a plain leaf node polls its parent every idle interval, 5 s default.
// RULE4: software should keep the poll interval within the parent timeout.
// RULE5: after the rejoin timeout of lost link, 10 s default, request a rejoin.
// RULE6: a plain leaf node never sleeps and keeps its radio on.
// RULE7: a sleeping node turns its radio off for the doze length, 8 quarters.
// RULE8: a sleeping node ignores the idle interval and cycles on the doze length.
// RULE9: doze expiry, button press or serial data wakes a sleeping node.
// RULE10: awake, the node polls every awake interval in ms, 100 default.
// RULE11: awake, the node sleeps again after the standby timeout without data.
// RULE12: any serial or radio data while awake restarts the standby timer.
// RULE13: the host should wake the node by button before sending serial data.
// RULE14: security level is 0 for none or 1 for network layer protection.
// RULE15: trust center denies a join whose link key differs; key resets to ones.
// RULE16: the network key protects all network traffic; set on the coordinator.
// RULE17: a key update is only stored; a later key switch makes it active.
// RULE18: a channel change message moves the node to the given channel.
// RULE19: once joined, the power indicator blinks.
// RULE20: all timers run from clock-derived ticks and restart on reset.
module epss_sched #(
  parameter int MS_CYCLES = `EPSS_MS_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // radio and host side events
  input  wire logic                    joined,
  input  wire logic                    link_up,
  input  wire logic                    rf_data,
  input  wire logic                    serial_data,
  input  wire logic                    button,
  input  wire logic                    key_switch,
  input  wire epss_pkg::epss_key_msg_t  key_update,
  input  wire epss_pkg::epss_key_msg_t  join_req,
  input  wire epss_pkg::epss_chan_msg_t chan_msg,
  input  wire epss_pkg::epss_child_ev_t child_reg,
  input  wire epss_pkg::epss_child_ev_t child_poll,
  input  wire logic [1:0]              relay_id,
  // outputs
  output logic                         poll_req,
  output logic                         rejoin_req,
  output logic                         radio_on,
  output logic                         power_led,
  output logic                         join_grant,
  output logic                         join_deny,
  output logic                         key_refresh_req,
  output logic                         security_on,
  output logic [127:0]                 nwk_key,
  output logic [4:0]                   channel,
  output logic                         relay_ok
);

  // byte-lane merge of a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // interval end: the tick that brings the count up to the limit
  function automatic logic expire(input logic [15:0] cnt, input logic [15:0] limit,
                                  input logic tick);
    expire = tick && (cnt + 16'h0001 >= limit);
  endfunction

  // configuration and state
  logic [2:0]            node_type;
  logic                  sec_level;
  logic [7:0]            child_tmo;
  logic [7:0]            idle_poll;
  logic [7:0]            rejoin_tmo;
  logic [7:0]            doze_len;
  logic [15:0]           awake_poll;
  logic [7:0]            standby_tmo;
  logic [127:0]          link_key;
  logic [127:0]          pend_key;
  logic                  key_pending;
  epss_pkg::epss_state_t state;
  epss_pkg::epss_state_t next_state;
  logic [15:0]           period_cnt;
  logic [15:0]           standby_cnt;
  logic [15:0]           rejoin_cnt;
  logic [1:0]            blink_cnt;
  logic                  blink;
  logic [3:0]            present;
  logic                  ms_tick;
  logic                  qtr_tick;
  logic                  sec_tick;

  epss_tick_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ticks (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ms_tick  (ms_tick),
    .qtr_tick (qtr_tick),
    .sec_tick (sec_tick)
  );

  epss_child_table u_children (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .sec_tick (sec_tick),
    .timeout  (child_tmo),
    .reg_ev   (child_reg),
    .poll_ev  (child_poll),
    .present  (present)
  );

  // write channel: both address and data must be offered before either is taken
  wire        wr_en  = awvalid && wvalid && !bvalid;
  wire [7:0]  wa     = awaddr & 8'hFC;
  wire        wa_key = (wa & 8'hF0) == `EPSS_OFF_LINK_KEY;
  wire        wa_nwk = (wa & 8'hF0) == `EPSS_OFF_NWK_KEY;
  wire [6:0]  kbase  = {awaddr[3:2], 5'h00};
  wire        wa_ok  = wa_key || wa_nwk || (wa <= `EPSS_OFF_CMD && wa != `EPSS_OFF_STATUS);
  wire        wr_ctl = wr_en && wa == `EPSS_OFF_CTRL;
  wire        wr_cmd = wr_en && wa == `EPSS_OFF_CMD && wstrb[0];
  assign awready = wr_en;
  assign wready  = wr_en;

  // read channel: one read outstanding, answered one cycle after address
  wire [7:0]  ra = araddr & 8'hFC;
  assign arready = !rvalid;

  // read mux; keys are write-only so they never leak onto the bus
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h00000000;
    case (ra)
      `EPSS_OFF_CTRL:       rd_word = {27'h0, sec_level, 1'b0, node_type};
      `EPSS_OFF_CHILD_TMO:  rd_word = {24'h0, child_tmo};
      `EPSS_OFF_IDLE_POLL:  rd_word = {24'h0, idle_poll};
      `EPSS_OFF_REJOIN:     rd_word = {24'h0, rejoin_tmo};
      `EPSS_OFF_DOZE:       rd_word = {24'h0, doze_len};
      `EPSS_OFF_AWAKE_POLL: rd_word = {16'h0, awake_poll};
      `EPSS_OFF_STANDBY:    rd_word = {24'h0, standby_tmo};
      `EPSS_OFF_STATUS:     rd_word = {11'h0, channel, 4'h0, present,
                                       1'b0, key_pending, link_up, joined, 4'(state)};
      `EPSS_OFF_CMD:        rd_word = 32'h00000000;
      default:              rd_ok   = ((ra & 8'hF0) == `EPSS_OFF_LINK_KEY) ||
                                      ((ra & 8'hF0) == `EPSS_OFF_NWK_KEY);
    endcase
  end

  // bus responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `EPSS_RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= `EPSS_RESP_OKAY;
      rdata  <= 32'h00000000;
    end else begin
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp  <= wa_ok ? `EPSS_RESP_OKAY : `EPSS_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_ok ? `EPSS_RESP_OKAY : `EPSS_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      node_type   <= 3'h0;
      sec_level   <= 1'b0;
      child_tmo   <= `EPSS_RST_CHILD_TMO;  // RULE1
      idle_poll   <= `EPSS_RST_IDLE_POLL;  // RULE3
      rejoin_tmo  <= `EPSS_RST_REJOIN;     // RULE5
      doze_len    <= `EPSS_RST_DOZE;       // RULE7
      awake_poll  <= `EPSS_RST_AWAKE_POLL; // RULE10
      standby_tmo <= `EPSS_RST_STANDBY;    // RULE11
    end else if (wr_en) begin
      if (wr_ctl && wstrb[0]) begin
        node_type <= wdata[2:0];
        sec_level <= wdata[`EPSS_CTRL_SEC_BIT]; // RULE14
      end
      case (wa)
        `EPSS_OFF_CHILD_TMO:  child_tmo   <= 8'(merge({24'h0, child_tmo}, wdata, wstrb));
        `EPSS_OFF_IDLE_POLL:  idle_poll   <= 8'(merge({24'h0, idle_poll}, wdata, wstrb));
        `EPSS_OFF_REJOIN:     rejoin_tmo  <= 8'(merge({24'h0, rejoin_tmo}, wdata, wstrb));
        `EPSS_OFF_DOZE:       doze_len    <= 8'(merge({24'h0, doze_len}, wdata, wstrb));
        `EPSS_OFF_AWAKE_POLL: awake_poll  <= 16'(merge({16'h0, awake_poll}, wdata, wstrb));
        `EPSS_OFF_STANDBY:    standby_tmo <= 8'(merge({24'h0, standby_tmo}, wdata, wstrb));
        default:              ;
      endcase
    end
  end
  assign security_on = sec_level;

  // keys: a key switch with an update pending wins over a software write to the network key in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_key    <= `EPSS_RST_KEY; // RULE15
      nwk_key     <= `EPSS_RST_KEY;
      pend_key    <= `EPSS_RST_KEY;
      key_pending <= 1'b0;
    end else begin
      if (wr_en && wa_key) begin
        link_key[kbase +: 32] <= merge(link_key[kbase +: 32], wdata, wstrb);
      end
      if (key_switch && key_pending) begin
        nwk_key <= pend_key; // RULE17
      end else if (wr_en && wa_nwk) begin
        nwk_key[kbase +: 32] <= merge(nwk_key[kbase +: 32], wdata, wstrb); // RULE16
      end
      if (key_update.valid) begin
        pend_key    <= key_update.key; // RULE17
        key_pending <= 1'b1;
      end else if (key_switch) begin
        key_pending <= 1'b0;
      end
    end
  end

  // trust center join check, channel moves and the refresh command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      join_grant      <= 1'b0;
      join_deny       <= 1'b0;
      channel         <= `EPSS_RST_CHANNEL;
      key_refresh_req <= 1'b0;
    end else begin
      join_grant      <= join_req.valid && node_type == `EPSS_NT_COORD &&
                         join_req.key == link_key;
      join_deny       <= join_req.valid && node_type == `EPSS_NT_COORD &&
                         join_req.key != link_key; // RULE15
      key_refresh_req <= wr_cmd && wdata[`EPSS_CMD_REFRESH];
      if (chan_msg.valid) begin
        channel <= chan_msg.chan; // RULE18
      end
    end
  end

  // relaying only for children still in the table
  assign relay_ok = present[relay_id]; // RULE2

  // leaf node state decode
  wire is_leaf   = node_type == `EPSS_NT_END || node_type == `EPSS_NT_SLEEPY;
  wire is_sleepy = node_type == `EPSS_NT_SLEEPY;
  wire activity  = rf_data || serial_data;
  wire idle_hit  = expire(period_cnt, {8'h0, idle_poll}, sec_tick);
  wire doze_hit  = expire(period_cnt, {8'h0, doze_len}, qtr_tick);
  wire awake_hit = expire(period_cnt, awake_poll, ms_tick);
  wire stby_hit  = !activity && sec_tick && standby_cnt >= {8'h0, standby_tmo};
  wire wake      = doze_hit || button || serial_data; // RULE9

  // leaf node state transitions
  always_comb begin
    next_state = state;
    case (state)
      epss_pkg::ST_OFF: begin
        if (joined && is_leaf) begin
          next_state = is_sleepy ? epss_pkg::ST_AWAKE : epss_pkg::ST_ACTIVE;
        end
      end
      epss_pkg::ST_ACTIVE: begin
        if (!joined || !is_leaf || is_sleepy) begin
          next_state = epss_pkg::ST_OFF; // RULE6
        end
      end
      epss_pkg::ST_AWAKE: begin
        if (!joined || !is_sleepy) begin
          next_state = epss_pkg::ST_OFF;
        end else if (stby_hit) begin
          next_state = epss_pkg::ST_DOZE; // RULE11
        end
      end
      epss_pkg::ST_DOZE: begin
        if (!joined || !is_sleepy) begin
          next_state = epss_pkg::ST_OFF;
        end else if (wake) begin
          next_state = epss_pkg::ST_AWAKE; // RULE9
        end
      end
      default: next_state = epss_pkg::ST_OFF;
    endcase
  end

  // period counter: seconds when active, quarters dozing, ms awake
  always_ff @(posedge aclk) begin
    if (!aresetn || next_state != state) begin
      period_cnt <= 16'h0000; // RULE20
    end else if ((state == epss_pkg::ST_ACTIVE && idle_hit) ||
                 (state == epss_pkg::ST_AWAKE && awake_hit)) begin
      period_cnt <= 16'h0000;
    end else if ((state == epss_pkg::ST_ACTIVE && sec_tick) ||  // RULE3
                 (state == epss_pkg::ST_DOZE && qtr_tick) ||    // RULE8
                 (state == epss_pkg::ST_AWAKE && ms_tick)) begin // RULE10
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  // standby counter, cleared by any data exchange
  always_ff @(posedge aclk) begin
    if (!aresetn || state != epss_pkg::ST_AWAKE || activity) begin
      standby_cnt <= 16'h0000; // RULE12
    end else if (sec_tick) begin
      standby_cnt <= standby_cnt + 16'h0001;
    end
  end

  // state, poll and rejoin outputs; a dozing node is not rejoining with its radio off
  wire link_lost = joined && is_leaf && !link_up && state != epss_pkg::ST_DOZE;
  wire rejoin_hit = expire(rejoin_cnt, {8'h0, rejoin_tmo}, sec_tick);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= epss_pkg::ST_OFF;
      poll_req   <= 1'b0;
      rejoin_req <= 1'b0;
      rejoin_cnt <= 16'h0000;
    end else begin
      state      <= next_state;
      poll_req   <= (state == epss_pkg::ST_ACTIVE && idle_hit) ||   // RULE3
                    (state == epss_pkg::ST_AWAKE && awake_hit) ||   // RULE10
                    (state == epss_pkg::ST_DOZE && doze_hit);       // RULE8
      rejoin_req <= link_lost && rejoin_hit; // RULE5
      if (!link_lost || rejoin_hit) begin
        rejoin_cnt <= 16'h0000;
      end else if (sec_tick) begin
        rejoin_cnt <= rejoin_cnt + 16'h0001;
      end
    end
  end

  // radio off only while dozing; a plain leaf never reaches that state
  assign radio_on = state != epss_pkg::ST_DOZE; // RULE7

  // power indicator: steady before joining, blinking after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt <= 2'h0;
      blink     <= 1'b0;
      power_led <= 1'b0;
    end else begin
      if (qtr_tick) begin
        blink_cnt <= (blink_cnt == `EPSS_BLINK_QTRS - 2'h1) ? 2'h0 : blink_cnt + 2'h1;
        if (blink_cnt == `EPSS_BLINK_QTRS - 2'h1) begin
          blink <= !blink;
        end
      end
      power_led <= joined ? blink : 1'b1; // RULE19
    end
  end

endmodule

// *** design/epss_tick_gen.sv ***
/*
  Millisecond, quarter-second and second tick pulses from the system clock.
  Assumes a synchronous active-low reset; all ticks restart from zero on reset.
*/
`timescale 1ns/10ps
`include "epss_defines.svh"

module epss_tick_gen #(
  parameter int MS_CYCLES = `EPSS_MS_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      ms_tick,
  output logic      qtr_tick,
  output logic      sec_tick
);

  logic [15:0] cyc_cnt;
  logic [7:0]  ms_cnt;
  logic [1:0]  qtr_cnt;
  wire         ms_end  = (cyc_cnt == 16'(MS_CYCLES - 1));
  wire         qtr_end = ms_end && (ms_cnt == `EPSS_MS_PER_QTR - 8'h01);
  wire         sec_end = qtr_end && (qtr_cnt == `EPSS_QTR_PER_SEC);

  // cascaded dividers, so the three ticks stay phase aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_cnt  <= 16'h0000;
      ms_cnt   <= 8'h00;
      qtr_cnt  <= 2'h0;
      ms_tick  <= 1'b0;
      qtr_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      cyc_cnt  <= ms_end ? 16'h0000 : cyc_cnt + 16'h0001; // RULE20
      ms_cnt   <= qtr_end ? 8'h00 : (ms_end ? ms_cnt + 8'h01 : ms_cnt);
      qtr_cnt  <= sec_end ? 2'h0 : (qtr_end ? qtr_cnt + 2'h1 : qtr_cnt);
      ms_tick  <= ms_end;
      qtr_tick <= qtr_end;
      sec_tick <= sec_end;
    end
  end

endmodule

// *** sim/epss_parent_model.sv ***
/*
  Parent node on the radio side: link state and poll answers.
  Assumes the bench chooses when the parent has data and how late it answers.
*/
`timescale 1ns/10ps

module epss_parent_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic poll_req,
  input  wire logic serve,
  input  wire logic slow,
  input  wire logic link_ok,
  output logic      link_up,
  output logic      rf_data
);
  logic [2:0] dly;

  // answers a poll with a frame; a late answer still counts as traffic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly     <= 3'h0;
      rf_data <= 1'h0;
      link_up <= 1'h0;
    end else begin
      link_up <= link_ok;
      rf_data <= dly == 3'h1;
      if (poll_req && serve) dly <= slow ? 3'h4 : 3'h2;
      else if (dly != 3'h0) dly <= dly - 3'h1;
    end
  end
endmodule

// *** sim/epss_sched_assertions.sv ***
/*
  Port checker for the poll/sleep scheduler.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/10ps

module epss_sched_chk (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     awvalid,
  input wire logic                     wvalid,
  input wire logic                     bvalid,
  input wire logic                     bready,
  input wire logic [1:0]               bresp,
  input wire logic                     arvalid,
  input wire logic                     arready,
  input wire logic                     rvalid,
  input wire logic                     button,
  input wire logic                     serial_data,
  input wire logic                     radio_on,
  input wire logic                     poll_req,
  input wire logic                     rejoin_req,
  input wire logic                     link_up,
  input wire epss_pkg::epss_key_msg_t  join_req,
  input wire logic                     join_grant,
  input wire logic                     join_deny,
  input wire epss_pkg::epss_chan_msg_t chan_msg,
  input wire logic [4:0]               channel
);
  // one domain, so clock and reset are stated once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_answer_a: assert property (awvalid && wvalid && !bvalid |=> bvalid)
    else $error("write not answered");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  poll_pulse_a: assert property (poll_req |=> !poll_req)
    else $error("poll pulse too long");
  rejoin_cause_a: assert property (rejoin_req |-> !$past(link_up))
    else $error("rejoin with link up");
  button_wake_a: assert property (button && !radio_on |=> radio_on)
    else $error("button did not wake");
  serial_wake_a: assert property (serial_data && !radio_on |=> radio_on)
    else $error("serial did not wake");
  join_cause_a: assert property (join_grant || join_deny |->
    $past(join_req.valid) && !(join_grant && join_deny)) else $error("join answer");
  chan_take_a: assert property (chan_msg.valid |=> channel == $past(chan_msg.chan))
    else $error("channel not taken");
endmodule

bind epss_sched epss_sched_chk u_chk (.*);

// *** sim/epss_sched_bench.sv ***
/*
  Self-checking bench of the poll/sleep scheduler.
  Assumes a design built with a ms tick of 10 cycles.
*/
`timescale 1ns/10ps

module epss_sched_bench;
  localparam int MS  = 10;
  localparam int QTR = MS * 250;
  localparam int SEC = QTR * 4;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, joined = 1'h0, serial_data = 1'h0, button = 1'h0;
  logic key_switch = 1'h0, serve = 1'h0, slow = 1'h0, link_ok = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, q;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] relay_id = 2'h0, r;
  epss_pkg::epss_key_msg_t key_update = '0, join_req = '0;
  epss_pkg::epss_chan_msg_t chan_msg = '0;
  epss_pkg::epss_child_ev_t child_reg = '0, child_poll = '0;
  wire awready, wready, bvalid, arready, rvalid, link_up, rf_data, poll_req, rejoin_req;
  wire radio_on, power_led, join_grant, join_deny, key_refresh_req, security_on, relay_ok;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [127:0] nwk_key;
  wire [4:0] channel;
  int num_errors = 0, n_checks = 0, n;
  logic [16:0] seed = 17'h14667;
  logic [127:0] k;
  logic [31:0] dflt [6] = '{32'h3C, 32'h05, 32'h0A, 32'h08, 32'h64, 32'h05};

  epss_sched #(.MS_CYCLES(MS)) DUT (.*);
  epss_parent_model PM (.*);

  always #25 aclk = ~aclk;

  function automatic logic [16:0] lf(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic stuck;
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict;
  endtask

  // one bus access; answer kept in q and r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge aclk);
    if (w) {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'h7};
    else {araddr, arvalid, rready} <= {a, 2'h3};
    do begin @(posedge aclk); i++; end while (!(w ? awready : arready) && i < 99);
    {awvalid, wvalid, arvalid} <= 3'h0;
    do begin @(posedge aclk); i++; end while (!(w ? bvalid : rvalid) && i < 99);
    q = rdata;
    r = w ? bresp : rresp;
    {bready, rready} <= 2'h0;
    if (i >= 99) stuck;
  endtask

  // bounded wait: 0 poll, 1 rejoin, 2 radio off, 3 radio on
  task automatic wt(input int s, input int lim);
    n = 0;
    do begin @(posedge aclk); n++; end
    while (!(s == 0 ? poll_req : s == 1 ? rejoin_req : s == 2 ? !radio_on : radio_on)
           && n < lim);
    if (n >= lim) stuck;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (dflt[i]) begin
      bus(0, 8'h04 + 8'(4 * i), 0);
      chk(q, dflt[i]);
    end
    bus(0, 8'h24, 0);
    chk(r, 2'h2);
    bus(1, 8'h1C, 0);
    chk(r, 2'h2);
    seed = lf(seed);
    bus(1, 8'h04, {29'h0, seed[2:0] | 3'h2});
    bus(0, 8'h04, 0);
    chk(q, {29'h0, seed[2:0] | 3'h2});
    bus(1, 8'h08, 32'h1);
    bus(1, 8'h0C, 32'h1);
    bus(1, 8'h00, 32'h13);
    chk(security_on, 1'h1);
    joined <= 1'h1;
    wt(0, 3 * SEC);
    wt(0, 2 * SEC);
    chk(n, SEC);
    chk(radio_on, 1'h1);
    link_ok <= 1'h0;
    wt(1, 2 * SEC);
    chk(n <= SEC + 2, 1'h1);
    link_ok <= 1'h1;
    // channel change and key update in the same cycle, the key held back until the switch
    seed = lf(seed);
    k = {4{15'h0, seed}};
    @(posedge aclk);
    chan_msg <= {1'h1, seed[4:0]};
    key_update <= {1'h1, k};
    child_reg <= 3'h4;
    @(posedge aclk);
    {chan_msg.valid, key_update.valid, child_reg.valid} <= 3'h0;
    @(posedge aclk);
    chk(channel, seed[4:0]);
    chk(relay_ok, 1'h1);
    chk(nwk_key, ~128'h0);
    key_switch <= 1'h1;
    @(posedge aclk);
    key_switch <= 1'h0;
    @(posedge aclk);
    chk(nwk_key, k);
    bus(1, 8'h20, 32'h1);
    chk(key_refresh_req, 1'h1);
    bus(1, 8'h00, 32'h1);
    for (int j = 0; j < 2; j++) begin
      @(posedge aclk);
      join_req <= {1'h1, j ? k : ~128'h0};
      @(posedge aclk);
      join_req.valid <= 1'h0;
      @(posedge aclk);
      chk(j ? join_deny : join_grant, 1'h1);
    end
    // sleeping node: 2 ms awake poll, 1 s standby, 2 quarter doze
    bus(1, 8'h14, 32'h2);
    bus(1, 8'h18, 32'h1);
    bus(1, 8'h10, 32'h2);
    bus(1, 8'h00, 32'h4);
    wt(0, SEC);
    wt(0, 99);
    chk(n, 2 * MS);
    {serve, slow} <= {1'h1, seed[1]};
    q[0] = power_led;
    repeat (2 * QTR) @(posedge aclk);
    chk(power_led, !q[0]);
    repeat (SEC - QTR) @(posedge aclk);
    chk(radio_on, 1'h1);
    serve <= 1'h0;
    wt(2, 3 * SEC);
    wt(3, 2 * QTR + 9);
    chk(n > QTR && n <= 2 * QTR, 1'h1);
    for (int j = 0; j < 2; j++) begin
      wt(2, 3 * SEC);
      @(posedge aclk);
      {serial_data, button} <= j ? 2'h2 : 2'h1;
      @(posedge aclk);
      {serial_data, button} <= 2'h0;
      @(posedge aclk);
      chk(radio_on, 1'h1);
    end
    chk(relay_ok, 1'h0);
    print_verdict;
  end
endmodule
